// ===== rtl/hrxb_pkg.sv
// constants and types shared by the harmonic restraint and cross-blocking block
package hrxb_pkg;
   // -----------------------------------------------------------------
   // clock and timing
   // -----------------------------------------------------------------
   localparam int CLK_HZ = 10_000_000;
   localparam int TICK_HZ = 1000;
   localparam int TICK_DIV = CLK_HZ / TICK_HZ;
   // times in units of 10 us (25 ms, 20.83 ms, 15 ms, 12.5 ms)
   localparam int QUAL_50_US10 = 2500;
   localparam int QUAL_60_US10 = 2083;
   localparam int DROP_50_US10 = 1500;
   localparam int DROP_60_US10 = 1250;
   localparam int US10_HZ = 100_000;
   localparam int US10_DIV = CLK_HZ / US10_HZ;
   // -----------------------------------------------------------------
   // settings
   // -----------------------------------------------------------------
   localparam int ANGLE_LIMIT_DEG = 75;
   localparam int MAG_MIN_PCT = 10;
   localparam int PCT_FULL = 100;
   localparam int RATIO_MIN_PCT = 5;
   localparam int RATIO_MAX_PCT = 50;
   localparam int RATIO2_DEF_PCT = 15;
   localparam int RATIO5_DEF_PCT = 25;
   localparam int XLIM_MIN_MS = 100;
   localparam int XLIM_MAX_MS = 60000;
   localparam int XLIM_DEF_MS = 5000;
   localparam bit XBLK_DEF = 1'b1;
   localparam int NPHASE = 3;
   localparam int DEG_FULL = 360;
   localparam int DEG_HALF = 180;
   typedef enum logic [1:0] {HRXB_IDLE, HRXB_QUAL, HRXB_HOLD, HRXB_DROP} hrxb_state_t;
endpackage

// ===== rtl/hrxb_harm_restraint.sv
// one phase, one harmonic: ratio compare, qualification and drop-off timing
`timescale 1ns/100ps
`default_nettype none
module hrxb_harm_restraint
   import hrxb_pkg::*;
#(
   parameter int MAG_W = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // timing
   input wire logic tick10us,
   input wire logic sixtyHz,
   // measurement
   input wire logic [MAG_W-1:0] fundMag,
   input wire logic [MAG_W-1:0] harmMag,
   input wire logic [6:0] ratioPct,
   input wire logic enable,
   // result
   output logic restrain
);
   localparam int CW = 12;
   hrxb_state_t state_reg, state_next;
   logic [CW-1:0] cnt_reg, cnt_next;
   logic restrain_reg, restrain_next;
   logic high;
   logic [CW-1:0] qualLen, dropLen;
   // harmonic*100 > ratio*fundamental, kept in integers
   always_comb begin
      high = enable && (fundMag != '0) &&
         ((MAG_W+7)'(harmMag) * (MAG_W+7)'(PCT_FULL) >
          (MAG_W+7)'(fundMag) * (MAG_W+7)'(ratioPct)); // RQ3
      qualLen = sixtyHz ? CW'(QUAL_60_US10) : CW'(QUAL_50_US10); // RQ5
      dropLen = sixtyHz ? CW'(DROP_60_US10) : CW'(DROP_50_US10); // RQ6
   end
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      case (state_reg)
         HRXB_IDLE: begin
            if (high) begin
               state_next = HRXB_QUAL; // RQ4
               cnt_next = '0;
            end
         end
         HRXB_QUAL: begin
            if (!high) begin
               state_next = HRXB_IDLE;
            end else if (tick10us) begin
               cnt_next = cnt_reg + 1'b1;
               if (cnt_reg + 1'b1 >= qualLen) begin
                  state_next = HRXB_HOLD; // RQ5
               end
            end
         end
         HRXB_HOLD: begin
            if (!high) begin
               state_next = HRXB_DROP;
               cnt_next = '0;
            end
         end
         default: begin
            if (high) begin
               state_next = HRXB_HOLD;
            end else if (!enable) begin
               state_next = HRXB_IDLE;
            end else if (tick10us) begin
               cnt_next = cnt_reg + 1'b1;
               if (cnt_reg + 1'b1 >= dropLen) begin
                  state_next = HRXB_IDLE; // RQ6
               end
            end
         end
      endcase
      restrain_next = high || (state_next == HRXB_DROP); // RQ4
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= HRXB_IDLE; // RQ16
         cnt_reg <= '0;
         restrain_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         restrain_reg <= restrain_next;
      end
   end
   assign restrain = restrain_reg;
   a_restrain_gate: assert property (@(posedge clk) disable iff (!resetn)
      !enable |=> !restrain) else $error("restraint without enable"); // RQ7
   a_hold_drop: assert property (@(posedge clk) disable iff (!resetn)
      (state_reg == HRXB_HOLD && !high) |=> restrain) else $error("no drop-off"); // RQ5
endmodule
`default_nettype wire

// ===== rtl/hrxb_top.sv
// harmonic restraint and timed cross-blocking for three measuring elements
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// RQ1: external fault is flagged when the two sides' shifted currents differ by 75 degrees or more.
// RQ2: the angle test counts only while both sides' magnitudes exceed 10% of reference current.
// RQ3: each phase compares harmonic over fundamental with a threshold common to all phases, 2nd and 5th apart.
// RQ4: a high ratio raises the phase restraint at once and starts a qualification timer.
// RQ5: a high ratio held 25 ms (20.83 ms at 60 Hz) arms a drop-off that prolongs the restraint.
// RQ6: the drop-off lasts 15 ms at 50 Hz and 12.5 ms at 60 Hz.
// RQ7: the 2nd harmonic restraint exists only while inrush or external fault is active.
// RQ8: the three 2nd harmonic restraints are ORed into one general inrush restraint.
// RQ9: the 5th harmonic path uses the same timing and is gated only by minimum diff current.
// RQ10: with cross-blocking off each element is blocked only by its own harmonics.
// RQ11: with cross-blocking on any harmonic block blocks all three elements.
// RQ12: cross-blocking ends at the time limit while harmonic elements still block themselves.
// RQ13: cross-blocking enable defaults to true.
// RQ14: the time limit spans 100 to 60000 ms in 1 ms steps with 5000 ms default.
// RQ15: ratio thresholds span 5 to 50 percent in 1 percent steps, defaults 15 and 25.
// RQ16: reset clears every timer and drops every restraint and condition output.
module hrxb_top
   import hrxb_pkg::*;
#(
   parameter int MAG_W = 16,
   parameter int ANG_W = 9,
   parameter int TICK_DIV_P = TICK_DIV,
   parameter int US10_DIV_P = US10_DIV
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // settings
   input wire logic sixtyHz,
   input wire logic crossBlockEnable,
   input wire logic [15:0] crossBlockTimeLimit,
   input wire logic [6:0] secondHarmRatioThreshold,
   input wire logic [6:0] fifthHarmRatioThreshold,
   input wire logic [MAG_W-1:0] refCurrent,
   input wire logic [MAG_W-1:0] minDiffCurrent,
   // conditions
   input wire logic inrushCondition,
   input wire logic [NPHASE*ANG_W-1:0] side1Angle,
   input wire logic [NPHASE*ANG_W-1:0] side2Angle,
   input wire logic [NPHASE*MAG_W-1:0] side1Mag,
   input wire logic [NPHASE*MAG_W-1:0] side2Mag,
   // differential current phasor magnitudes
   input wire logic [NPHASE*MAG_W-1:0] fundDiffMag,
   input wire logic [NPHASE*MAG_W-1:0] secondDiffMag,
   input wire logic [NPHASE*MAG_W-1:0] fifthDiffMag,
   // decisions
   output logic extFaultCondition,
   output logic [NPHASE-1:0] secondHarmRestraint,
   output logic [NPHASE-1:0] fifthHarmRestraint,
   output logic anyPhaseSecondHarmRestraint,
   output logic anyPhaseFifthHarmRestraint,
   output logic [NPHASE-1:0] elementBlock,
   output logic crossBlockActive
);
   initial begin
      if (MAG_W < 8 || ANG_W < 9 || TICK_DIV_P < 1 || US10_DIV_P < 1) begin
         $error("hrxb_top: unsupported parameter");
      end
   end
   // -----------------------------------------------------------------
   // time base dividers
   // -----------------------------------------------------------------
   logic [23:0] msDiv_reg, msDiv_next, usDiv_reg, usDiv_next;
   logic tickMs_reg, tickMs_next, tick10us_reg, tick10us_next;
   always_comb begin
      tickMs_next = (msDiv_reg == 24'(TICK_DIV_P - 1));
      msDiv_next = tickMs_next ? '0 : msDiv_reg + 1'b1;
      tick10us_next = (usDiv_reg == 24'(US10_DIV_P - 1));
      usDiv_next = tick10us_next ? '0 : usDiv_reg + 1'b1;
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         msDiv_reg <= '0;
         usDiv_reg <= '0;
         tickMs_reg <= 1'b0;
         tick10us_reg <= 1'b0;
      end else begin
         msDiv_reg <= msDiv_next;
         usDiv_reg <= usDiv_next;
         tickMs_reg <= tickMs_next;
         tick10us_reg <= tick10us_next;
      end
   end
   // -----------------------------------------------------------------
   // setting limits
   // -----------------------------------------------------------------
   logic [6:0] ratio2, ratio5;
   logic [15:0] xLimit;
   function automatic logic [6:0] clampPct(input logic [6:0] v);
      if (v < 7'(RATIO_MIN_PCT)) begin
         clampPct = 7'(RATIO_MIN_PCT);
      end else if (v > 7'(RATIO_MAX_PCT)) begin
         clampPct = 7'(RATIO_MAX_PCT);
      end else begin
         clampPct = v;
      end
   endfunction
   always_comb begin
      ratio2 = clampPct(secondHarmRatioThreshold); // RQ15
      ratio5 = clampPct(fifthHarmRatioThreshold); // RQ15
      if (crossBlockTimeLimit < 16'(XLIM_MIN_MS)) begin
         xLimit = 16'(XLIM_MIN_MS); // RQ14
      end else if (crossBlockTimeLimit > 16'(XLIM_MAX_MS)) begin
         xLimit = 16'(XLIM_MAX_MS); // RQ14
      end else begin
         xLimit = crossBlockTimeLimit;
      end
   end
   // -----------------------------------------------------------------
   // external fault condition
   // -----------------------------------------------------------------
   logic extFault_reg, extFault_next;
   logic [NPHASE-1:0] phaseExt;
   genvar g;
   generate
      for (g = 0; g < NPHASE; g++) begin : gAng
         logic [ANG_W-1:0] a1, a2, d, dw;
         logic [MAG_W+6:0] m1, m2, lim;
         always_comb begin
            a1 = side1Angle[g*ANG_W +: ANG_W];
            a2 = side2Angle[g*ANG_W +: ANG_W];
            d = (a1 >= a2) ? a1 - a2 : a2 - a1;
            dw = (d > ANG_W'(DEG_HALF)) ? ANG_W'(DEG_FULL) - d : d;
            m1 = (MAG_W+7)'(side1Mag[g*MAG_W +: MAG_W]) * (MAG_W+7)'(PCT_FULL);
            m2 = (MAG_W+7)'(side2Mag[g*MAG_W +: MAG_W]) * (MAG_W+7)'(PCT_FULL);
            lim = (MAG_W+7)'(refCurrent) * (MAG_W+7)'(MAG_MIN_PCT);
            phaseExt[g] = (m1 > lim) && (m2 > lim) // RQ2
               && (dw >= ANG_W'(ANGLE_LIMIT_DEG)); // RQ1
         end
      end
   endgenerate
   assign extFault_next = |phaseExt;
   // -----------------------------------------------------------------
   // per-phase harmonic restraint
   // -----------------------------------------------------------------
   logic [NPHASE-1:0] r2, r5;
   logic gate2;
   assign gate2 = inrushCondition || extFault_reg; // RQ7
   generate
      for (g = 0; g < NPHASE; g++) begin : gPh
         logic minOk;
         assign minOk = fundDiffMag[g*MAG_W +: MAG_W] > minDiffCurrent; // RQ9
         hrxb_harm_restraint #(.MAG_W(MAG_W)) uSecond (
            .clk(clk),
            .resetn(resetn),
            .tick10us(tick10us_reg),
            .sixtyHz(sixtyHz),
            .fundMag(fundDiffMag[g*MAG_W +: MAG_W]),
            .harmMag(secondDiffMag[g*MAG_W +: MAG_W]),
            .ratioPct(ratio2),
            .enable(gate2 && minOk),
            .restrain(r2[g])
         );
         hrxb_harm_restraint #(.MAG_W(MAG_W)) uFifth (
            .clk(clk),
            .resetn(resetn),
            .tick10us(tick10us_reg),
            .sixtyHz(sixtyHz),
            .fundMag(fundDiffMag[g*MAG_W +: MAG_W]),
            .harmMag(fifthDiffMag[g*MAG_W +: MAG_W]),
            .ratioPct(ratio5),
            .enable(minOk),
            .restrain(r5[g])
         );
      end
   endgenerate
   // -----------------------------------------------------------------
   // cross-blocking
   // -----------------------------------------------------------------
   logic [15:0] xCnt_reg, xCnt_next;
   logic xAct_reg, xAct_next, xDone_reg, xDone_next;
   logic [NPHASE-1:0] selfBlk, blk_reg, blk_next;
   logic anyBlk;
   always_comb begin
      selfBlk = r2 | r5; // RQ10
      anyBlk = |selfBlk;
      xCnt_next = xCnt_reg;
      xDone_next = xDone_reg;
      if (!anyBlk || !crossBlockEnable) begin
         xCnt_next = '0;
         xDone_next = 1'b0;
      end else if (!xDone_reg && tickMs_reg) begin
         xCnt_next = xCnt_reg + 1'b1;
         if (xCnt_reg + 1'b1 >= xLimit) begin
            xDone_next = 1'b1; // RQ12
         end
      end
      xAct_next = crossBlockEnable && anyBlk && !xDone_next; // RQ11 RQ13
      blk_next = xAct_next ? {NPHASE{1'b1}} : selfBlk; // RQ11
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         extFault_reg <= 1'b0; // RQ16
         xCnt_reg <= '0;
         xAct_reg <= 1'b0;
         xDone_reg <= 1'b0;
         blk_reg <= '0;
      end else begin
         extFault_reg <= extFault_next;
         xCnt_reg <= xCnt_next;
         xAct_reg <= xAct_next;
         xDone_reg <= xDone_next;
         blk_reg <= blk_next;
      end
   end
   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   logic any2_reg, any5_reg;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         any2_reg <= 1'b0;
         any5_reg <= 1'b0;
      end else begin
         any2_reg <= |r2; // RQ8
         any5_reg <= |r5;
      end
   end
   assign extFaultCondition = extFault_reg;
   assign secondHarmRestraint = r2;
   assign fifthHarmRestraint = r5;
   assign anyPhaseSecondHarmRestraint = any2_reg;
   assign anyPhaseFifthHarmRestraint = any5_reg;
   assign elementBlock = blk_reg;
   assign crossBlockActive = xAct_reg;
   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   a_any_second: assert property (@(posedge clk) disable iff (!resetn)
      any2_reg == $past(|r2)) else $error("general inrush flag mismatch"); // RQ8
   a_self_block: assert property (@(posedge clk) disable iff (!resetn)
      (|(r2 | r5)) |=> (|blk_reg)) else $error("missing self block"); // RQ10
   a_no_cross_off: assert property (@(posedge clk) disable iff (!resetn)
      !crossBlockEnable |=> !xAct_reg) else $error("cross block while disabled"); // RQ10
   a_cross_all: assert property (@(posedge clk) disable iff (!resetn)
      xAct_reg |-> (blk_reg == {NPHASE{1'b1}})) else $error("cross block incomplete"); // RQ11
   a_cross_limit: assert property (@(posedge clk) disable iff (!resetn)
      xAct_reg |-> (xCnt_reg < xLimit)) else $error("cross block past limit"); // RQ12
   a_ext_needs_mag: assert property (@(posedge clk) disable iff (!resetn)
      (refCurrent != '0 && side1Mag == '0) |=> !extFault_reg)
      else $error("ext fault with low magnitude"); // RQ2
   a_second_gate: assert property (@(posedge clk) disable iff (!resetn)
      (!inrushCondition && !extFault_reg)[*2] |=> (r2 == '0))
      else $error("second harmonic restraint ungated"); // RQ7
   a_self_kept: assert property (@(posedge clk) disable iff (!resetn)
      (xDone_reg && !xAct_reg) |-> ((blk_reg & ~$past(selfBlk)) == '0))
      else $error("released element still blocked"); // RQ12
   c_cross: cover property (@(posedge clk) disable iff (!resetn) xAct_reg);
   c_release: cover property (@(posedge clk) disable iff (!resetn) $fell(xAct_reg) && anyBlk);
   c_ext: cover property (@(posedge clk) disable iff (!resetn) extFault_reg && |r2);
   c_fifth: cover property (@(posedge clk) disable iff (!resetn) any5_reg);
endmodule
`default_nettype wire

// ===== dv/hrxb_meas_model.sv
// upstream measurement model: differential phasor magnitudes built from requested ratios
`timescale 1ns/100ps
`default_nettype none
module hrxb_meas_model
   import hrxb_pkg::*;
#(
   parameter int MAG_W = 16
) (
   // requested content
   input wire logic [MAG_W-1:0] fundLevel,
   input wire logic [NPHASE*7-1:0] secondPct,
   input wire logic [NPHASE*7-1:0] fifthPct,
   // phasor magnitudes
   output logic [NPHASE*MAG_W-1:0] fundDiffMag,
   output logic [NPHASE*MAG_W-1:0] secondDiffMag,
   output logic [NPHASE*MAG_W-1:0] fifthDiffMag
);
   // harmonic magnitude is fundLevel/100, truncated, times the requested percentage per phase
   always_comb begin
      for (int g = 0; g < NPHASE; g++) begin
         fundDiffMag[g*MAG_W +: MAG_W] = fundLevel;
         secondDiffMag[g*MAG_W +: MAG_W] = MAG_W'(fundLevel / 100 * secondPct[g*7 +: 7]);
         fifthDiffMag[g*MAG_W +: MAG_W] = MAG_W'(fundLevel / 100 * fifthPct[g*7 +: 7]);
      end
   end
endmodule
`default_nettype wire

// ===== dv/testbench.sv
// self-checking bench for harmonic restraint and cross-blocking
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import hrxb_pkg::*;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic sixtyHz = 1'b0;
   logic crossBlockEnable = 1'b1;
   logic [15:0] crossBlockTimeLimit = 16'h1388;
   logic [6:0] secondHarmRatioThreshold = 7'h0f;
   logic [6:0] fifthHarmRatioThreshold = 7'h19;
   logic [15:0] refCurrent = 16'h03e8;
   logic [15:0] minDiffCurrent = 16'h0064;
   logic inrushCondition = 1'b0;
   logic [26:0] side1Angle = '0;
   logic [26:0] side2Angle = '0;
   logic [47:0] side1Mag = {3{16'h00c8}};
   logic [47:0] side2Mag = {3{16'h00c8}};
   logic [15:0] fundLevel = 16'h03e8;
   logic [20:0] secondPct = '0;
   logic [20:0] fifthPct = '0;
   logic [47:0] fundDiffMag, secondDiffMag, fifthDiffMag;
   logic extFaultCondition, anyPhaseSecondHarmRestraint, anyPhaseFifthHarmRestraint;
   logic crossBlockActive;
   logic [2:0] secondHarmRestraint, fifthHarmRestraint, elementBlock;
   int fail_count = 0;
   int check_count = 0;
   int n;
   logic [8:0] angA [4] = '{9'h000, 9'h000, 9'h15e, 9'h000};
   logic [8:0] angB [4] = '{9'h04b, 9'h04a, 9'h041, 9'h04b};
   logic [15:0] magB [4] = '{16'h00c8, 16'h00c8, 16'h0065, 16'h0064};
   logic expF [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

   always #50 clk = ~clk;

   hrxb_meas_model #(.MAG_W(16)) model (.fundLevel(fundLevel), .secondPct(secondPct),
      .fifthPct(fifthPct), .fundDiffMag(fundDiffMag), .secondDiffMag(secondDiffMag),
      .fifthDiffMag(fifthDiffMag));

   hrxb_top #(.MAG_W(16), .ANG_W(9), .TICK_DIV_P(10), .US10_DIV_P(1)) dut (.clk(clk),
      .resetn(resetn), .sixtyHz(sixtyHz), .crossBlockEnable(crossBlockEnable),
      .crossBlockTimeLimit(crossBlockTimeLimit),
      .secondHarmRatioThreshold(secondHarmRatioThreshold),
      .fifthHarmRatioThreshold(fifthHarmRatioThreshold), .refCurrent(refCurrent),
      .minDiffCurrent(minDiffCurrent), .inrushCondition(inrushCondition),
      .side1Angle(side1Angle), .side2Angle(side2Angle), .side1Mag(side1Mag),
      .side2Mag(side2Mag), .fundDiffMag(fundDiffMag), .secondDiffMag(secondDiffMag),
      .fifthDiffMag(fifthDiffMag), .extFaultCondition(extFaultCondition),
      .secondHarmRestraint(secondHarmRestraint), .fifthHarmRestraint(fifthHarmRestraint),
      .anyPhaseSecondHarmRestraint(anyPhaseSecondHarmRestraint),
      .anyPhaseFifthHarmRestraint(anyPhaseFifthHarmRestraint), .elementBlock(elementBlock),
      .crossBlockActive(crossBlockActive));

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wt(input int c);
      repeat (c) @(negedge clk);
   endtask

   task automatic done(input string name);
      $display("test %s finished, mismatches so far %0d", name, fail_count);
   endtask

   // fifth ratio on phase 0 held for hold cycles, then drop-off of dropLen expected
   task automatic burst(input int hold, input int dropLen);
      fifthPct[6:0] = 7'h1a;
      wt(hold);
      fifthPct[6:0] = 7'h00;
      if (dropLen > 0) begin
         wt(dropLen - 100);
         chk(fifthHarmRestraint[0], 1);
         wt(200);
      end else begin
         wt(5);
      end
      chk(fifthHarmRestraint[0], 0);
   endtask

   // ---------------------------------------------------------------
   // sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (40000) @(posedge clk);
      fail_count++;
      stop_test();
   end

   initial begin
      wt(20);
      chk({extFaultCondition, secondHarmRestraint, fifthHarmRestraint, elementBlock}, 0);
      chk({anyPhaseSecondHarmRestraint, anyPhaseFifthHarmRestraint, crossBlockActive}, 0);
      resetn = 1'b1;
      wt(5);
      done("reset");
      fifthPct[6:0] = 7'h1a;
      wt(4);
      chk(fifthHarmRestraint, 3'b001);
      chk(anyPhaseFifthHarmRestraint, 1);
      chk({crossBlockActive, elementBlock}, 4'b1111);
      minDiffCurrent = 16'h03e8;
      wt(4);
      chk(fifthHarmRestraint, 3'b000);
      minDiffCurrent = 16'h0064;
      fifthPct[6:0] = 7'h19;
      wt(4);
      chk(fifthHarmRestraint, 3'b000);
      chk(elementBlock, 3'b000);
      done("fifth immediate");
      burst(3000, 1500);
      burst(2200, 0);
      sixtyHz = 1'b1;
      burst(2200, 1250);
      sixtyHz = 1'b0;
      done("drop-off timing");
      fifthHarmRatioThreshold = 7'h03;
      fifthPct[13:7] = 7'h04;
      wt(4);
      chk(fifthHarmRestraint, 3'b000);
      fifthPct[13:7] = 7'h06;
      wt(4);
      chk(fifthHarmRestraint, 3'b010);
      fifthHarmRatioThreshold = 7'h3c;
      fifthPct[13:7] = 7'h32;
      wt(4);
      chk(fifthHarmRestraint, 3'b000);
      fifthPct[13:7] = 7'h33;
      wt(4);
      chk(fifthHarmRestraint, 3'b010);
      fifthPct[13:7] = 7'h00;
      fifthHarmRatioThreshold = 7'h19;
      wt(10);
      done("threshold limits");
      crossBlockEnable = 1'b0;
      fifthPct[20:14] = 7'h1a;
      wt(4);
      chk({crossBlockActive, elementBlock}, 4'b0100);
      fifthPct[20:14] = 7'h00;
      crossBlockEnable = 1'b1;
      wt(10);
      done("cross-blocking off");
      secondPct[13:7] = 7'h10;
      wt(4);
      chk({anyPhaseSecondHarmRestraint, secondHarmRestraint}, 4'b0000);
      inrushCondition = 1'b1;
      wt(4);
      chk({anyPhaseSecondHarmRestraint, secondHarmRestraint}, 4'b1010);
      chk(elementBlock, 3'b111);
      inrushCondition = 1'b0;
      wt(4);
      chk(secondHarmRestraint, 3'b000);
      secondPct[13:7] = 7'h00;
      wt(10);
      done("second gating");
      for (int i = 0; i < 4; i++) begin
         side1Angle[8:0] = angA[i];
         side2Angle[8:0] = angB[i];
         side2Mag[15:0] = magB[i];
         wt(3);
         chk(extFaultCondition, expF[i]);
      end
      side2Mag[15:0] = 16'h00c8;
      side1Mag = '0;
      wt(3);
      chk(extFaultCondition, 0);
      side1Mag = {3{16'h00c8}};
      secondPct[6:0] = 7'h10;
      wt(4);
      chk({extFaultCondition, secondHarmRestraint}, 4'b1001);
      secondPct[6:0] = 7'h00;
      side2Angle[8:0] = 9'h000;
      wt(10);
      done("external fault");
      crossBlockTimeLimit = 16'h0032;
      fifthPct[6:0] = 7'h1a;
      n = 0;
      while (crossBlockActive !== 1'b0 || n < 5) begin
         wt(1);
         n++;
         if (n > 3000) begin
            fail_count++;
            stop_test();
         end
      end
      chk(n >= 950 && n <= 1050, 1);
      wt(2);
      chk(elementBlock, 3'b001);
      fifthPct[6:0] = 7'h00;
      wt(10);
      done("cross-block limit");
      fifthPct[6:0] = 7'h1a;
      wt(4);
      chk(fifthHarmRestraint, 3'b001);
      resetn = 1'b0;
      fifthPct[6:0] = 7'h00;
      wt(2);
      chk({extFaultCondition, secondHarmRestraint, fifthHarmRestraint, elementBlock}, 0);
      chk({anyPhaseSecondHarmRestraint, anyPhaseFifthHarmRestraint, crossBlockActive}, 0);
      resetn = 1'b1;
      wt(4);
      chk({fifthHarmRestraint, elementBlock, crossBlockActive}, 0);
      done("mid-run reset");
      stop_test();
   end
endmodule
`default_nettype wire
